//--- hw/kpi_pkg.sv
// Purpose: Shared constants for the keypad pin interrupt block.
// Assumes: 8-bit register port, one word per offset.
// Notes:   Offsets index the plain register port directly.
package kpi_pkg;
	localparam int unsigned NPINS   = 8;
	localparam int unsigned NUPPER  = 4;
	localparam int unsigned ADDR_W  = 4;
	localparam int unsigned DATA_W  = 8;
	localparam int unsigned NEVT    = 2;

	// Register offsets
	localparam logic [ADDR_W-1:0] OFF_STATUS_CONTROL = 4'h0;
	localparam logic [ADDR_W-1:0] OFF_PIN_ENABLE     = 4'h1;
	localparam logic [ADDR_W-1:0] OFF_EVT_STATUS     = 4'h2;
	localparam logic [ADDR_W-1:0] OFF_EVT_MASK       = 4'h3;
	localparam logic [ADDR_W-1:0] OFF_PIN_ASSERTED   = 4'h4;

	// Field positions in key_interrupt_status_control
	localparam int unsigned BIT_EDGE_LSB = 4;
	localparam int unsigned BIT_FLAG     = 3;
	localparam int unsigned BIT_ACK      = 2;
	localparam int unsigned BIT_IRQ_EN   = 1;
	localparam int unsigned BIT_MODE     = 0;

	// Field positions in the event status and mask registers
	localparam int unsigned EVT_TRIGGER  = 0;
	localparam int unsigned EVT_ACK_HELD = 1;

	// Reset values
	localparam logic [DATA_W-1:0] RST_STATUS_CONTROL = 8'h00;
	localparam logic [NPINS-1:0]  RST_PIN_ENABLE     = 8'h00;
	localparam logic [NEVT-1:0]   RST_EVT_STATUS     = 2'h0;
	localparam logic [NEVT-1:0]   RST_EVT_MASK       = 2'h0;
	// Pins idle high through pull-ups; syncs start there, so no edge
	localparam logic [NPINS-1:0]  RST_PINS_SYNC      = 8'hFF;
	localparam logic [DATA_W-1:0] RST_RDATA          = 8'h00;
	localparam logic              RST_IRQ            = 1'h0;

	typedef enum logic {
		KPI_MODE_EDGE,
		KPI_MODE_EDGE_LEVEL
	} kpi_mode_t;
endpackage : kpi_pkg

//--- hw/kpi_det_if.sv
// Purpose: Carries synchronised pins, detect setup and triggers.
// Assumes: One clock domain on both sides.
// Notes:   Shared by the synchroniser, detector and top.
`timescale 1ns/1ps
interface kpi_det_if;
	import kpi_pkg::*;
	logic [NPINS-1:0]  pins_sync;
	logic [NUPPER-1:0] edge_sel;
	logic [NPINS-1:0]  pin_en;
	logic              mode;
	logic [NPINS-1:0]  trig;
	logic [NPINS-1:0]  asserted;

	modport sync (output pins_sync);
	modport detect (
		input  pins_sync,
		input  edge_sel,
		input  pin_en,
		input  mode,
		output trig,
		output asserted
	);
	modport ctrl (
		output edge_sel,
		output pin_en,
		output mode,
		input  trig,
		input  asserted
	);
endinterface : kpi_det_if

//--- hw/kpi_pin_sync.sv
// Purpose: Two-stage synchroniser for the keypad pins.
// Assumes: Pins are asynchronous to i_clock.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/1ps
module kpi_pin_sync
	import kpi_pkg::*;
(
	input  wire logic                     i_clock,  // Bus clock
	input  wire logic                     i_arst_n, // Async reset, low
	input  wire logic [kpi_pkg::NPINS-1:0] i_pins,  // Raw pins
	kpi_det_if.sync                       det       // Synced pins out
);
	logic [NPINS-1:0] meta_r;

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			meta_r        <= RST_PINS_SYNC;
			det.pins_sync <= RST_PINS_SYNC;
		end else begin
			meta_r        <= i_pins;    // R10
			det.pins_sync <= meta_r;    // R10
		end
	end
endmodule : kpi_pin_sync

//--- hw/kpi_detect.sv
// Purpose: Per-pin edge and level trigger detection.
// Assumes: Pins already synchronised to i_clock.
// Notes:   Lower pins have a fixed low/falling sense.
`timescale 1ns/1ps
module kpi_detect
	import kpi_pkg::*;
(
	input  wire logic i_clock,  // Bus clock
	input  wire logic i_arst_n, // Async reset, low
	kpi_det_if.detect det       // Setup in, triggers out
);
	logic [NPINS-1:0] prev_r;

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			prev_r <= RST_PINS_SYNC;
		end else begin
			prev_r <= det.pins_sync;    // R10
		end
	end

	genvar n;
	generate
		for (n = 0; n < NPINS; n++) begin : g_pin
			logic pol;
			logic now_hit;
			logic was_hit;
			if (n >= NUPPER) begin : g_up
				assign pol = det.edge_sel[n-NUPPER];    // R01
			end else begin : g_lo
				assign pol = 1'b0;                      // R09
			end
			// Same polarity on both samples: a polarity change is no edge
			assign now_hit = ~(det.pins_sync[n] ^ pol);
			assign was_hit = ~(prev_r[n] ^ pol);
			assign det.asserted[n] = now_hit;
			assign det.trig[n] = det.pin_en[n] &                    // R02
				((now_hit & ~was_hit) |                             // R10
				 (det.mode & now_hit));                             // R08
		end
	endgenerate
endmodule : kpi_detect

//--- hw/kpi_top.sv
// Purpose: Keypad pin interrupt block with its register port.
// Assumes: Single 10 MHz bus clock; pins asynchronous to it.
// Notes:   Read data stand one cycle after the read strobe.
//
// Summary of operation
// R01 - Upper pin polarity bits choose sense
// R02 - Only enabled pins can trigger
// R03 - Any trigger sets read-only pending flag
// R04 - Acknowledge write clears flag, flag unwritable
// R05 - Held level keeps flag set despite acknowledge
// R06 - Acknowledge bit always reads zero
// R07 - Enable bit gates request onto interrupt
// R08 - Mode bit picks edge or edge-and-level
// R09 - Lower pins fixed falling/low sense
// R10 - Pins synchronised, edge by sample compare
//
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module kpi_top
	import kpi_pkg::*;
(
	input  wire logic                       i_clock,    // Bus clock
	input  wire logic                       i_arst_n,   // Async reset
	input  wire logic [kpi_pkg::NPINS-1:0]  i_key_pins, // Keypad pins
	input  wire logic [kpi_pkg::ADDR_W-1:0] i_addr,     // Register index
	input  wire logic [kpi_pkg::DATA_W-1:0] i_wdata,    // Write data
	input  wire logic                       i_wr,       // Write strobe
	input  wire logic                       i_rd,       // Read strobe
	output logic      [kpi_pkg::DATA_W-1:0] o_rdata,    // Read data
	output logic                            o_irq       // Interrupt
);
	import kpi_pkg::*;

	// Register decode for the write strobes; the read mux cases on i_addr
	function automatic logic reg_hit(
		input logic [ADDR_W-1:0] addr,
		input logic [ADDR_W-1:0] off
	);
		reg_hit = (addr == off);
	endfunction : reg_hit

	// Write-one-to-clear with set winning over clear
	function automatic logic [NEVT-1:0] w1c_update(
		input logic [NEVT-1:0] cur,
		input logic [NEVT-1:0] set,
		input logic [NEVT-1:0] clr
	);
		w1c_update = (cur & ~clr) | set;
	endfunction : w1c_update

	// Mode decode shared by the detector, the ack guard and read-back
	function automatic logic level_mode(
		input kpi_mode_t m
	);
		level_mode = (m == KPI_MODE_EDGE_LEVEL);
	endfunction : level_mode

	kpi_det_if det_bus ();

	kpi_pin_sync u_sync (
		.i_clock  (i_clock),
		.i_arst_n (i_arst_n),
		.i_pins   (i_key_pins),
		.det      (det_bus.sync)
	);

	kpi_detect u_detect (
		.i_clock  (i_clock),
		.i_arst_n (i_arst_n),
		.det      (det_bus.detect)
	);

	// Control state
	logic [NUPPER-1:0] edge_polarity_select_r;
	kpi_mode_t         detect_mode_select_r;
	logic              key_irq_enable_r;
	logic              key_event_flag_r;
	logic              key_event_flag_nxt;
	logic [NPINS-1:0]  pin_participation_enable_r;
	logic [NEVT-1:0]   evt_status_r;
	logic [NEVT-1:0]   evt_status_nxt;
	logic [NEVT-1:0]   evt_mask_r;
	logic [DATA_W-1:0] rdata_r;
	logic [DATA_W-1:0] rdata_nxt;
	logic              irq_r;
	logic              irq_nxt;
	logic              key_irq_enable_nxt;
	logic [NEVT-1:0]   evt_mask_nxt;
	logic              key_req_nxt;
	logic              evt_req_nxt;
	logic [DATA_W-1:0] sc_image;

	// Decoded strobes
	logic wr_sc;
	logic wr_pin_en;
	logic wr_evt_stat;
	logic wr_evt_mask;
	logic ack_write;
	logic any_trigger;
	logic level_held;
	logic ack_refused;

	assign wr_sc       = i_wr & reg_hit(i_addr, OFF_STATUS_CONTROL);
	assign wr_pin_en   = i_wr & reg_hit(i_addr, OFF_PIN_ENABLE);
	assign wr_evt_stat = i_wr & reg_hit(i_addr, OFF_EVT_STATUS);
	assign wr_evt_mask = i_wr & reg_hit(i_addr, OFF_EVT_MASK);

	// The acknowledge bit is a strobe only; nothing stores it
	assign ack_write = wr_sc & i_wdata[BIT_ACK];    // R04

	assign any_trigger = |det_bus.trig;    // R03

	// A level trigger still present means the acknowledge cannot stick
	assign level_held = level_mode(detect_mode_select_r) &
		|(det_bus.asserted & pin_participation_enable_r);
	assign ack_refused = ack_write & level_held;    // R05

	// Detect setup towards the detector
	assign det_bus.edge_sel = edge_polarity_select_r;    // R01
	assign det_bus.pin_en   = pin_participation_enable_r;    // R02
	assign det_bus.mode     = level_mode(detect_mode_select_r);    // R08

	// Polarity and mode live in the status/control register
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			edge_polarity_select_r <=
				RST_STATUS_CONTROL[BIT_EDGE_LSB +: NUPPER];
		end else if (wr_sc) begin
			edge_polarity_select_r <=
				i_wdata[BIT_EDGE_LSB +: NUPPER];    // R01
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			detect_mode_select_r <=
				kpi_mode_t'(RST_STATUS_CONTROL[BIT_MODE]);
		end else if (wr_sc) begin
			detect_mode_select_r <=
				kpi_mode_t'(i_wdata[BIT_MODE]);    // R08
		end
	end

	// Interrupt request enable, as it will stand after this edge
	always_comb begin
		key_irq_enable_nxt = key_irq_enable_r;
		if (wr_sc) begin
			key_irq_enable_nxt = i_wdata[BIT_IRQ_EN];    // R07
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			key_irq_enable_r <= RST_STATUS_CONTROL[BIT_IRQ_EN];
		end else begin
			key_irq_enable_r <= key_irq_enable_nxt;
		end
	end

	// Pin participation enables
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pin_participation_enable_r <= RST_PIN_ENABLE;
		end else if (wr_pin_en) begin
			pin_participation_enable_r <= i_wdata[NPINS-1:0];    // R02
		end
	end

	// Pending flag: a trigger in the acknowledge cycle wins, so a
	// held level in edge-and-level mode re-sets it every cycle.
	always_comb begin
		key_event_flag_nxt = key_event_flag_r;
		if (ack_write) begin
			key_event_flag_nxt = 1'b0;    // R04
		end
		if (any_trigger) begin
			key_event_flag_nxt = 1'b1;    // R03 R05
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			key_event_flag_r <= RST_STATUS_CONTROL[BIT_FLAG];
		end else begin
			key_event_flag_r <= key_event_flag_nxt;
		end
	end

	// Sticky event status, cleared by writing ones
	always_comb begin
		logic [NEVT-1:0] set_v;
		logic [NEVT-1:0] clr_v;
		set_v = '0;
		clr_v = '0;
		set_v[EVT_TRIGGER]  = any_trigger;
		set_v[EVT_ACK_HELD] = ack_refused;
		if (wr_evt_stat) begin
			clr_v = i_wdata[NEVT-1:0];
		end
		evt_status_nxt = w1c_update(evt_status_r, set_v, clr_v);
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			evt_status_r <= RST_EVT_STATUS;
		end else begin
			evt_status_r <= evt_status_nxt;
		end
	end

	// Mask as it will stand after this edge
	always_comb begin
		evt_mask_nxt = evt_mask_r;
		if (wr_evt_mask) begin
			evt_mask_nxt = i_wdata[NEVT-1:0];
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			evt_mask_r <= RST_EVT_MASK;
		end else begin
			evt_mask_r <= evt_mask_nxt;
		end
	end

	// The request is built from next-state values so that it moves with
	// the flag, the enable and the mask in the same cycle; costs a wider
	// cone before the output flop, but no lag behind a register write.
	always_comb begin
		key_req_nxt = key_irq_enable_nxt & key_event_flag_nxt;    // R07
		evt_req_nxt = |(evt_status_nxt & evt_mask_nxt);
		irq_nxt     = key_req_nxt | evt_req_nxt;
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			irq_r <= RST_IRQ;
		end else begin
			irq_r <= irq_nxt;
		end
	end

	// Status/control image; the acknowledge position has no storage
	always_comb begin
		sc_image = '0;
		sc_image[BIT_EDGE_LSB +: NUPPER] = edge_polarity_select_r;
		sc_image[BIT_FLAG]   = key_event_flag_r;    // R03
		sc_image[BIT_ACK]    = 1'b0;    // R06
		sc_image[BIT_IRQ_EN] = key_irq_enable_r;
		sc_image[BIT_MODE]   = level_mode(detect_mode_select_r);
	end

	// Read mux; unmapped indices read as zero
	always_comb begin
		rdata_nxt = '0;
		if (i_rd) begin
			case (i_addr)
				OFF_STATUS_CONTROL: begin
					rdata_nxt = sc_image;
				end
				OFF_PIN_ENABLE: begin
					rdata_nxt[NPINS-1:0] = pin_participation_enable_r;
				end
				OFF_EVT_STATUS: begin
					rdata_nxt[NEVT-1:0] = evt_status_r;
				end
				OFF_EVT_MASK: begin
					rdata_nxt[NEVT-1:0] = evt_mask_r;
				end
				OFF_PIN_ASSERTED: begin
					// Live view, useful to see why a flag will not clear
					rdata_nxt[NPINS-1:0] = det_bus.asserted;
				end
				default: begin
					rdata_nxt = '0;
				end
			endcase
		end
	end

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rdata_r <= RST_RDATA;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	assign o_rdata = rdata_r;
	assign o_irq   = irq_r;
endmodule : kpi_top

//--- test/kpi_top_properties.sv
// Purpose: Port-level assertions for the keypad pin interrupt block.
// Assumes: Event mask stays zero outside the bench's mask test.
// Notes:   Shadows rebuild setup from register writes alone.
`timescale 1ns/1ps
module kpi_checker
	import kpi_pkg::*;
(
	input  wire logic                       i_clock,    // Bus clock
	input  wire logic                       i_arst_n,   // Async reset
	input  wire logic [kpi_pkg::NPINS-1:0]  i_key_pins, // Keypad pins
	input  wire logic [kpi_pkg::ADDR_W-1:0] i_addr,     // Register index
	input  wire logic [kpi_pkg::DATA_W-1:0] i_wdata,    // Write data
	input  wire logic                       i_wr,       // Write strobe
	input  wire logic                       i_rd,       // Read strobe
	input  wire logic [kpi_pkg::DATA_W-1:0] o_rdata,    // Read data
	input  wire logic                       o_irq       // Interrupt
);
	logic [7:0] ctl_r;
	logic [7:0] en_r;
	logic [7:0] pins_r;
	logic [1:0] msk_r;
	logic [1:0] quiet_r;

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ctl_r <= 8'h00;
			en_r <= 8'h00;
			msk_r <= 2'h0;
		end else if (i_wr) begin
			if (i_addr == OFF_STATUS_CONTROL)
				ctl_r <= i_wdata;
			if (i_addr == OFF_PIN_ENABLE)
				en_r <= i_wdata;
			if (i_addr == OFF_EVT_MASK)
				msk_r <= i_wdata[1:0];
		end
	end

	// Quiet count covers the two sync flops plus the trigger stage
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pins_r <= 8'hFF;
			quiet_r <= 2'h0;
		end else begin
			pins_r <= i_key_pins;
			if (i_key_pins != pins_r)
				quiet_r <= 2'h0;
			else if (quiet_r != 2'h3)
				quiet_r <= quiet_r + 2'h1;
		end
	end

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_arst_n);

	sequence s_lower_fall;
		|(pins_r[3:0] & ~i_key_pins[3:0] & en_r[3:0]);
	endsequence
	sequence s_ack_quiet;
		i_wr && i_addr == OFF_STATUS_CONTROL && i_wdata[BIT_ACK]
		&& quiet_r == 2'h3 && msk_r == 2'h0;
	endsequence

	AST_RDATA_IDLE: assert property (
		!$past(i_rd) |-> o_rdata == 8'h00)
		else $error("read data not zero outside read");
	AST_ACK_READS_ZERO: assert property (
		$past(i_rd) && $past(i_addr) == OFF_STATUS_CONTROL
		|-> !o_rdata[BIT_ACK]) else $error("ack bit read as one");
	AST_IRQ_FOLLOWS_FLAG: assert property (
		$past(i_rd) && $past(i_addr) == OFF_STATUS_CONTROL
		&& o_rdata[BIT_FLAG] && o_rdata[BIT_IRQ_EN] |-> o_irq)
		else $error("flag and enable set but no irq");
	AST_IRQ_GATED: assert property (
		!ctl_r[BIT_IRQ_EN] && msk_r == 2'h0 |-> !o_irq)
		else $error("irq while disabled");
	AST_EDGE_IRQ: assert property (
		s_lower_fall ##0 ctl_r[BIT_IRQ_EN] |-> ##3 o_irq)
		else $error("falling edge gave no irq");
	AST_ACK_CLEARS: assert property (
		s_ack_quiet ##0 !ctl_r[BIT_MODE] && !i_wdata[BIT_MODE]
		|=> !o_irq) else $error("ack left irq set");
	AST_LEVEL_HOLDS: assert property (
		s_ack_quiet ##0 ctl_r[BIT_MODE] && i_wdata[BIT_MODE]
		&& i_wdata[BIT_IRQ_EN] && |(en_r[3:0] & ~i_key_pins[3:0])
		|=> o_irq) else $error("held level cleared by ack");
	AST_ASSERTED_VIEW: assert property (
		$past(i_rd) && $past(i_addr) == OFF_PIN_ASSERTED
		&& $past(quiet_r) == 2'h3 |-> o_rdata ==
		~($past(i_key_pins) ^ {$past(ctl_r[7:4]), 4'h0}))
		else $error("asserted level view wrong");
endmodule : kpi_checker

//--- test/kpi_keys_model.sv
// Purpose: Keypad switches with pull-ups for the pin inputs.
// Assumes: Bench names the wanted levels.
// Notes:   Levels move only after a clock edge.
`timescale 1ns/1ps
module kpi_keys_model (
	input  wire logic       i_clock, // Bus clock
	input  wire logic [7:0] i_want,  // Wanted levels
	output logic      [7:0] o_pins   // Pin levels
);
	// Released keys sit high through their pull-ups
	initial o_pins = 8'hFF;
	always @(posedge i_clock)
		o_pins <= i_want;
endmodule : kpi_keys_model

//--- test/kpi_tb_top.sv
// Purpose: Self-checking bench for the keypad pin interrupt block.
// Assumes: Register port reads answer one cycle after the strobe.
// Notes:   Keys held six cycles so sync and trigger settle.
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin \
 miscompares++; $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module kpi_tb_top;
	import kpi_pkg::*;
	logic       i_clock = 1'b0;
	logic       i_arst_n = 1'b0;
	logic [7:0] want = 8'hFF;
	logic [7:0] keys;
	logic [3:0] i_addr = 4'h0;
	logic [7:0] i_wdata = 8'h00;
	logic [7:0] o_rdata;
	logic       i_wr = 1'b0;
	logic       i_rd = 1'b0;
	logic       o_irq;
	int         miscompares = 0;
	int         checked = 0;

	always #50 i_clock = ~i_clock;

	kpi_keys_model u_keys (.i_clock(i_clock), .i_want(want), .o_pins(keys));
	kpi_top uut (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_key_pins(keys),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .o_irq(o_irq));

	task automatic tally_and_finish;
		$display("checked=%0d miscompares=%0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish

	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= v;
		@(posedge i_clock);
		i_wr <= 1'b0;
		#1;
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clock);
		i_rd <= 1'b0;
		#1;
		`CHK(o_rdata, e)
	endtask : rd

	task automatic press(input logic [7:0] v);
		want <= v;
		repeat (6) @(posedge i_clock);
		#1;
	endtask : press

	initial begin
		repeat (2000) @(posedge i_clock);
		miscompares++;
		tally_and_finish;
	end

	initial begin
		repeat (8) @(posedge i_clock);
		i_arst_n <= 1'b1;
		@(posedge i_clock);
		#1;
		for (int a = 0; a < 4; a++)
			rd(a[3:0], 8'h00);
		rd(OFF_PIN_ASSERTED, 8'h00);
		rd(4'hF, 8'h00);
		wr(OFF_PIN_ENABLE, 8'h01);
		wr(OFF_STATUS_CONTROL, 8'h02);
		press(8'hFD);
		rd(OFF_STATUS_CONTROL, 8'h02);
		press(8'hFC);
		rd(OFF_STATUS_CONTROL, 8'h0A);
		`CHK(o_irq, 1'b1)
		rd(OFF_EVT_STATUS, 8'h01);
		// Flag bit written high too: it must not stick
		wr(OFF_STATUS_CONTROL, 8'h0E);
		rd(OFF_STATUS_CONTROL, 8'h02);
		`CHK(o_irq, 1'b0)
		wr(OFF_PIN_ENABLE, 8'h80);
		press(8'hFF);
		wr(OFF_STATUS_CONTROL, 8'h82);
		rd(OFF_PIN_ASSERTED, 8'h80);
		press(8'h7F);
		rd(OFF_STATUS_CONTROL, 8'h82);
		press(8'hFF);
		rd(OFF_STATUS_CONTROL, 8'h8A);
		wr(OFF_STATUS_CONTROL, 8'h06);
		rd(OFF_STATUS_CONTROL, 8'h02);
		wr(OFF_PIN_ENABLE, 8'h01);
		wr(OFF_EVT_STATUS, 8'h03);
		press(8'hFE);
		wr(OFF_STATUS_CONTROL, 8'h06);
		rd(OFF_STATUS_CONTROL, 8'h02);
		wr(OFF_STATUS_CONTROL, 8'h07);
		wr(OFF_STATUS_CONTROL, 8'h07);
		rd(OFF_STATUS_CONTROL, 8'h0B);
		rd(OFF_EVT_STATUS, 8'h03);
		press(8'hFF);
		wr(OFF_STATUS_CONTROL, 8'h07);
		rd(OFF_STATUS_CONTROL, 8'h03);
		// Upper pin: falling sense, then rising sense with level held
		wr(OFF_PIN_ENABLE, 8'h80);
		wr(OFF_STATUS_CONTROL, 8'h04);
		press(8'h7F);
		rd(OFF_STATUS_CONTROL, 8'h08);
		`CHK(o_irq, 1'b0)
		wr(OFF_STATUS_CONTROL, 8'h87);
		rd(OFF_STATUS_CONTROL, 8'h83);
		press(8'hFF);
		wr(OFF_STATUS_CONTROL, 8'h87);
		rd(OFF_STATUS_CONTROL, 8'h8B);
		wr(OFF_PIN_ENABLE, 8'h01);
		wr(OFF_STATUS_CONTROL, 8'h00);
		wr(OFF_EVT_STATUS, 8'h03);
		wr(OFF_EVT_MASK, 8'h01);
		rd(OFF_EVT_MASK, 8'h01);
		press(8'hFE);
		rd(OFF_STATUS_CONTROL, 8'h08);
		`CHK(o_irq, 1'b1)
		wr(OFF_EVT_STATUS, 8'h01);
		`CHK(o_irq, 1'b0)
		wr(OFF_EVT_MASK, 8'h00);
		wr(OFF_PIN_ASSERTED, 8'h00);
		rd(OFF_PIN_ASSERTED, 8'h01);
		tally_and_finish;
	end
endmodule : kpi_tb_top

bind kpi_top kpi_checker u_chk (.i_clock(i_clock), .i_arst_n(i_arst_n),
	.i_key_pins(i_key_pins), .i_addr(i_addr), .i_wdata(i_wdata),
	.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq));
